// ===== core/rusf_cfg.svh
// Purpose: Constants of the radar UDP stream framer
// Assumes: Included by bare name from the CRC, framer, host model and bench files
// Notes: Numbers only; types live in rusf_pkg
//
// Operation
// RULE1 - Marker datagram, then record datagrams, repeating
// RULE2 - Marker is 24 bytes, two fixed words
// RULE3 - Sequence count steps once per marker
// RULE4 - Marker carries trailing length and CRC-32
// RULE5 - Data portion holds only header-plus-payload records
// RULE6 - Header carries transmit and receive channel labels
// RULE7 - Ramp index per channel starts at one
// RULE8 - Stage code: raw, DC-cancelled, first FFT
// RULE9 - Format code: unsigned16, signed16, float32
// RULE10 - Raw sent as uint16, FFT as float32
// RULE11 - Sample count equals samples in payload
// RULE12 - Payload bytes equal format size times count
// RULE13 - Record length is header, payload and CRC
// RULE14 - Default addresses 192.168.0.1, port 5001
// RULE15 - Address changes last only until reset
// RULE16 - Echo requests are answered
// RULE17 - Whole cube collected, then sent as unit
// RULE18 - Labels, codes 8 bits; index, count 16
// RULE19 - One byte order everywhere: big endian
// RULE20 - Record trailer is Ethernet CRC-32
`ifndef RUSF_CFG_SVH
`define RUSF_CFG_SVH

// ***************************************************
// Marker and record layout
// ***************************************************
`define RUSF_MARK_W1 32'h1234_5678
`define RUSF_MARK_W2 32'hAA55_AA55
`define RUSF_MARK_BYTES 32'h0000_0018
`define RUSF_REC_HDR_BYTES 32'h0000_0008
`define RUSF_REC_CRC_BYTES 32'h0000_0004

// ***************************************************
// Record codes
// ***************************************************
`define RUSF_STAGE_RAW 8'h00
`define RUSF_STAGE_DC 8'h01
`define RUSF_STAGE_FFT 8'h02
`define RUSF_FMT_U16 8'h00
`define RUSF_FMT_S16 8'h01
`define RUSF_FMT_F32 8'h02
`define RUSF_SIZE_NARROW 32'h0000_0002
`define RUSF_SIZE_WIDE 32'h0000_0004

// ***************************************************
// Addressing defaults and CRC
// ***************************************************
`define RUSF_DEF_SRC_IP 32'hC0A8_0001
`define RUSF_DEF_DST_IP 32'hC0A8_0001
`define RUSF_DEF_DST_PORT 16'h1389
`define RUSF_CRC_POLY 32'hEDB8_8320
`define RUSF_CRC_INIT 32'hFFFF_FFFF

// ***************************************************
// Storage sizes
// ***************************************************
`define RUSF_SMP_AW 16
`define RUSF_HDR_AW 11
`define RUSF_CHANS 16

`endif

// ===== core/rusf_crc32.sv
// Purpose: Byte-wide Ethernet CRC-32, reflected form
// Assumes: Init and update never in the same cycle
// Notes: Final value is the inverted register
`timescale 1ns/1ps
`default_nettype none
`include "rusf_cfg.svh"
module rusf_crc32 import rusf_pkg::*; (
   input wire logic clk_sys_i, // System clock
   input wire logic rst_i, // Async reset, high
   input wire logic init_i, // Restart the sum
   input wire logic en_i, // Fold in one byte
   input wire logic [7:0] byte_i, // Byte to fold
   output logic [31:0] crc_o // Final CRC value
);
   logic [31:0] crc;
   logic [31:0] next_crc;

   // One bit per step, LSB first as on the wire
   always_comb begin
      next_crc = crc;
      for (int i = 0; i < 8; i++) begin
         if (next_crc[0] ^ byte_i[i]) begin
            next_crc = {1'b0, next_crc[31:1]} ^ `RUSF_CRC_POLY;
         end else begin
            next_crc = {1'b0, next_crc[31:1]};
         end
      end
   end

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         crc <= `RUSF_CRC_INIT;
      end else if (init_i) begin
         crc <= `RUSF_CRC_INIT;
      end else if (en_i) begin
         crc <= next_crc;
      end
   end

   assign crc_o = ~crc;
endmodule // rusf_crc32
`default_nettype wire

// ===== core/rusf_framer.sv
// Purpose: Collects one radar cube and frames it as marker and record datagrams
// Assumes: Size and stage inputs steady while a cube is collected and sent
// Notes: Byte stream out, MSB first; UDP/IP wrapping is done downstream
`timescale 1ns/1ps
`default_nettype none
`include "rusf_cfg.svh"
module rusf_framer import rusf_pkg::*; (
   input wire logic clk_sys_i, // System clock, 25 MHz
   input wire logic rst_i, // Async reset, high
   input wire rusf_smp_t smp_i, // Incoming sample with ramp labels
   input wire logic smp_valid_i, // Sample offered
   output logic smp_ready_o, // Sample taken when valid
   input wire logic [15:0] samples_per_ramp_i, // Samples in one ramp
   input wire logic [15:0] ramps_per_cube_i, // Ramps in one cube
   input wire logic [7:0] stage_i, // Processing stage code
   input wire rusf_addr_cfg_t cfg_i, // Address change strobes
   input wire logic echo_req_i, // Echo request pulse
   input wire logic [31:0] echo_tag_i, // Id and sequence of request
   output rusf_byte_t tx_o, // Outgoing datagram byte
   output logic tx_valid_o, // Byte offered
   input wire logic tx_ready_i, // Byte taken
   output logic [31:0] src_ip_o, // Own address
   output logic [31:0] dst_ip_o, // Host address
   output logic [15:0] dst_port_o // Host port
);
   rusf_state_t state;
   rusf_kind_t kind;
   logic [63:0] sh;
   logic [3:0] left;
   logic first_pend, echo_pend;
   logic [31:0] echo_tag, cube_sequence_count, dg_cnt;
   logic [16:0] wr_addr;
   logic [15:0] wr_ramp, rd_ramp, rd_smp, rd_addr;
   logic [15:0] chan_cnt [`RUSF_CHANS];
   logic [31:0] smp_rd, hdr_rd, crc_fin;

   // ***************************************************
   // Decode
   // ***************************************************
   wire logic [7:0] fmt = (stage_i == `RUSF_STAGE_FFT) ? `RUSF_FMT_F32 :
                          (stage_i == `RUSF_STAGE_DC) ? `RUSF_FMT_S16 : `RUSF_FMT_U16; // RULE9
   wire logic wide = (fmt == `RUSF_FMT_F32); // RULE10
   wire logic [31:0] smp_size = wide ? `RUSF_SIZE_WIDE : `RUSF_SIZE_NARROW;
   wire logic [31:0] pay_bytes = 32'(samples_per_ramp_i) * smp_size; // RULE12
   wire logic [31:0] rec_bytes = `RUSF_REC_HDR_BYTES + pay_bytes + `RUSF_REC_CRC_BYTES; // RULE13
   wire logic [31:0] trailing_byte_length = 32'(ramps_per_cube_i) * rec_bytes; // RULE4
   wire logic [31:0] cube_prod = 32'(samples_per_ramp_i) * 32'(ramps_per_cube_i);
   wire logic [16:0] cube_total = cube_prod[16:0];
   wire logic cube_full = (wr_addr == cube_total) && (cube_total != 17'h0_0000);

   // Handshakes and sequencing terms
   wire logic out_st = state inside {S_MA, S_MB, S_MC, S_HDR, S_PAY, S_CRC, S_ECHO};
   wire logic beat = tx_valid_o && tx_ready_i;
   wire logic seg_end = beat && (left == 4'h1);
   wire logic last_rec = (rd_ramp == ramps_per_cube_i - 16'h0001);
   wire logic last_smp = (rd_smp == samples_per_ramp_i - 16'h0001);
   wire logic start_echo = (state == S_CAP) && echo_pend; // RULE16
   wire logic cube_go = (state == S_CAP) && !echo_pend && cube_full; // RULE17
   wire logic crc_end = (state == S_CRC) && seg_end;
   wire logic chan_clr = crc_end && (kind == RUSF_K_RECORD) && last_rec;

   // Capture side: ready only while collecting, so no cube is sent half-filled
   wire logic cap_acc = smp_valid_i && smp_ready_o;
   wire logic ramp_acc = cap_acc && smp_i.ramp_start;
   wire logic [3:0] chan_sel = {smp_i.transmit_channel_label[1:0],
                                smp_i.receive_channel_label[1:0]};
   wire logic [15:0] cur_idx = chan_cnt[chan_sel] + 16'h0001; // RULE7
   assign smp_ready_o = (state == S_CAP) && !cube_full && !echo_pend; // RULE17

   // Output byte: data straight from the shift register
   assign tx_valid_o = out_st && (left != 4'h0);
   assign tx_o.data = sh[63:56]; // RULE19
   assign tx_o.first = first_pend;
   assign tx_o.last = (left == 4'h1) && (state == S_CRC || state == S_ECHO); // RULE1
   assign tx_o.kind = kind;

   // ***************************************************
   // Storage
   // ***************************************************
   rusf_ram #(.AW(`RUSF_SMP_AW), .DW(32)) u_smp_ram (
      .clk_sys_i(clk_sys_i),
      .wr_en_i(cap_acc),
      .wr_addr_i(wr_addr[15:0]),
      .wr_data_i(smp_i.sample),
      .rd_addr_i(rd_addr),
      .rd_data_o(smp_rd)
   );

   // Header word: transmit label, receive label, ramp index
   rusf_ram #(.AW(`RUSF_HDR_AW), .DW(32)) u_hdr_ram (
      .clk_sys_i(clk_sys_i),
      .wr_en_i(ramp_acc),
      .wr_addr_i(wr_ramp[10:0]),
      .wr_data_i({smp_i.transmit_channel_label, smp_i.receive_channel_label, cur_idx}), // RULE6
      .rd_addr_i(rd_ramp[10:0]),
      .rd_data_o(hdr_rd)
   );

   rusf_crc32 u_crc (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .init_i(cube_go || state == S_HWT),
      .en_i(beat && state != S_CRC && state != S_ECHO), // RULE20
      .byte_i(sh[63:56]),
      .crc_o(crc_fin)
   );

   // ***************************************************
   // Per-channel ramp counters
   // ***************************************************
   // Only the low two bits of each label pick a counter: 4x4 channels max
   for (genvar g = 0; g < `RUSF_CHANS; g++) begin : g_chan
      always_ff @(posedge clk_sys_i or posedge rst_i) begin
         if (rst_i) begin
            chan_cnt[g] <= 16'h0000;
         end else if (chan_clr) begin
            chan_cnt[g] <= 16'h0000;
         end else if (ramp_acc && chan_sel == 4'(g)) begin
            chan_cnt[g] <= cur_idx; // RULE7
         end
      end
   end

   // Capture pointers, cleared once the cube has gone out
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         wr_addr <= 17'h0_0000;
         wr_ramp <= 16'h0000;
      end else if (chan_clr) begin
         wr_addr <= 17'h0_0000;
         wr_ramp <= 16'h0000;
      end else begin
         if (cap_acc) wr_addr <= wr_addr + 17'h0_0001;
         if (ramp_acc) wr_ramp <= wr_ramp + 16'h0001;
      end
   end

   // ***************************************************
   // Sequencer
   // ***************************************************
   // Shift by default; a segment end reloads the register for the next part
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         state <= S_CAP;
         sh <= 64'h0000_0000_0000_0000;
         left <= 4'h0;
      end else begin
         if (beat) begin
            sh <= {sh[55:0], 8'h00};
            left <= left - 4'h1;
         end
         case (state)
            S_CAP: begin
               if (start_echo) begin
                  state <= S_ECHO;
                  sh <= {echo_tag, 32'h0000_0000}; // RULE16
                  left <= 4'h4;
               end else if (cube_go) begin
                  state <= S_MA;
                  sh <= {`RUSF_MARK_W1, `RUSF_MARK_W2}; // RULE2
                  left <= 4'h8;
               end
            end
            S_MA: if (seg_end) begin
               state <= S_MB;
               sh <= {cube_sequence_count, trailing_byte_length}; // RULE3 RULE4
               left <= 4'h8;
            end
            S_MB: if (seg_end) begin
               state <= S_MC;
               sh <= 64'h0000_0000_0000_0000;
               left <= 4'h4;
            end
            S_MC: if (seg_end) state <= S_CRC;
            S_CRC: begin
               // Empty register means the sum is complete: load it
               if (left == 4'h0) begin
                  sh <= {crc_fin, 32'h0000_0000}; // RULE4 RULE20
                  left <= 4'h4;
               end else if (seg_end) begin
                  state <= (kind == RUSF_K_RECORD && last_rec) ? S_CAP : S_HRD; // RULE1 RULE5
               end
            end
            S_HRD: state <= S_HWT;
            S_HWT: begin
               state <= S_HDR;
               sh <= {hdr_rd, stage_i, fmt, samples_per_ramp_i}; // RULE8 RULE11 RULE18
               left <= 4'h8;
            end
            S_HDR: if (seg_end) state <= S_PRD;
            S_PRD: state <= S_PWT;
            S_PWT: begin
               state <= S_PAY;
               sh <= wide ? {smp_rd, 32'h0000_0000} : {smp_rd[15:0], 48'h0000_0000_0000}; // RULE10
               left <= wide ? 4'h4 : 4'h2; // RULE12
            end
            S_PAY: if (seg_end) state <= last_smp ? S_CRC : S_PRD;
            S_ECHO: if (seg_end) state <= S_CAP;
            default: state <= S_CAP;
         endcase
      end
   end

   // Read pointers, datagram kind and sequence count
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         rd_ramp <= 16'h0000;
         rd_smp <= 16'h0000;
         rd_addr <= 16'h0000;
         kind <= RUSF_K_MARKER;
         first_pend <= 1'b0;
         cube_sequence_count <= 32'h0000_0000;
         dg_cnt <= 32'h0000_0000;
      end else begin
         if (beat) first_pend <= 1'b0;
         if (beat) dg_cnt <= dg_cnt + 32'h0000_0001;
         if (cube_go || start_echo || state == S_HWT) begin
            first_pend <= 1'b1;
            dg_cnt <= 32'h0000_0000;
         end
         if (cube_go) begin
            kind <= RUSF_K_MARKER;
            rd_ramp <= 16'h0000;
            rd_addr <= 16'h0000;
         end
         if (start_echo) kind <= RUSF_K_ECHO;
         if (state == S_HWT) begin
            kind <= RUSF_K_RECORD;
            rd_smp <= 16'h0000;
         end
         if (state == S_PAY && seg_end) begin
            rd_smp <= rd_smp + 16'h0001;
            rd_addr <= rd_addr + 16'h0001;
         end
         if (crc_end && kind == RUSF_K_RECORD) rd_ramp <= rd_ramp + 16'h0001;
         if (crc_end && kind == RUSF_K_MARKER) begin
            cube_sequence_count <= cube_sequence_count + 32'h0000_0001; // RULE3
         end
      end
   end

   // ***************************************************
   // Echo request and addressing
   // ***************************************************
   // A request arriving as the old one is served stays pending
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         echo_pend <= 1'b0;
         echo_tag <= 32'h0000_0000;
      end else begin
         echo_pend <= echo_req_i || (echo_pend && !start_echo); // RULE16
         if (echo_req_i) echo_tag <= echo_tag_i;
      end
   end

   // Changes are volatile: reset restores the defaults
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         src_ip_o <= `RUSF_DEF_SRC_IP; // RULE14 RULE15
         dst_ip_o <= `RUSF_DEF_DST_IP;
         dst_port_o <= `RUSF_DEF_DST_PORT;
      end else begin
         if (cfg_i.set_src) src_ip_o <= cfg_i.ip;
         if (cfg_i.set_dst) begin
            dst_ip_o <= cfg_i.ip;
            dst_port_o <= cfg_i.port;
         end
      end
   end

   // ***************************************************
   // Checks
   // ***************************************************
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);

   AST_MARK_W1: assert property ( // RULE2
      beat && tx_o.first && kind == RUSF_K_MARKER |-> tx_o.data == 8'h12)
      else $error("marker does not open with first marker word");
   AST_MARK_LEN: assert property ( // RULE2
      beat && tx_o.last && kind == RUSF_K_MARKER |-> dg_cnt == `RUSF_MARK_BYTES - 32'h1)
      else $error("marker is not 24 bytes");
   AST_SEQ_STEP: assert property ( // RULE3
      crc_end && kind == RUSF_K_MARKER |=> cube_sequence_count == $past(cube_sequence_count) + 1)
      else $error("sequence count did not step");
   AST_LEN_FIELD: assert property ( // RULE4
      state == S_MA && seg_end |=> sh[31:0] == trailing_byte_length)
      else $error("length field wrong");
   AST_REC_LEN: assert property ( // RULE13
      beat && tx_o.last && kind == RUSF_K_RECORD |-> dg_cnt == rec_bytes - 32'h1)
      else $error("record length wrong");
   AST_COUNT: assert property ( // RULE11
      state == S_HWT |=> state == S_HDR && sh[15:0] == samples_per_ramp_i && sh[23:16] == fmt)
      else $error("sample count or format field wrong");
   AST_RAW_FMT: assert property ( // RULE10
      state == S_PWT && stage_i == `RUSF_STAGE_RAW |=> left == 4'h2)
      else $error("raw sample not two bytes");
   AST_HOLD: assert property ( // RULE17
      state != S_CAP |-> !smp_ready_o)
      else $error("sample taken while sending");
   AST_ECHO: assert property ( // RULE16
      start_echo |=> state == S_ECHO && tx_valid_o ##[1:8] state == S_CAP)
      else $error("echo not answered");
   AST_DEFAULT: assert property ( // RULE14
      $past(rst_i) |-> src_ip_o == `RUSF_DEF_SRC_IP && dst_port_o == `RUSF_DEF_DST_PORT)
      else $error("default addressing lost");
   AST_IDX_ONE: assert property ( // RULE7
      state == S_HWT |=> sh[47:32] != 16'h0000)
      else $error("ramp index zero");
   AST_AFTER_MARK: assert property ( // RULE1
      crc_end && kind == RUSF_K_MARKER |=> state == S_HRD ##1 state == S_HWT)
      else $error("records do not follow marker");

   COV_MARKER: cover property (crc_end && kind == RUSF_K_MARKER);
   COV_CUBE: cover property (chan_clr);
   COV_ECHO: cover property (state == S_ECHO && seg_end);
   COV_STALL: cover property (tx_valid_o && !tx_ready_i ##1 beat);
endmodule // rusf_framer
`default_nettype wire

// ===== core/rusf_pkg.sv
// Purpose: Types shared by the stream framer files
// Assumes: Nothing beyond the tool's SystemVerilog support
// Notes: Constants are macros in rusf_cfg.svh
package rusf_pkg;

   // ***************************************************
   // Sequencer states and datagram kinds
   // ***************************************************
   typedef enum logic [3:0] {
      S_CAP, S_MA, S_MB, S_MC, S_HRD, S_HWT, S_HDR, S_PRD, S_PWT, S_PAY, S_CRC, S_ECHO
   } rusf_state_t;

   typedef enum logic [1:0] {RUSF_K_MARKER, RUSF_K_RECORD, RUSF_K_ECHO} rusf_kind_t;

   // ***************************************************
   // Carriers
   // ***************************************************
   typedef struct packed {
      logic ramp_start;
      logic [7:0] transmit_channel_label;
      logic [7:0] receive_channel_label;
      logic [31:0] sample;
   } rusf_smp_t;

   typedef struct packed {
      logic [7:0] data;
      logic first;
      logic last;
      rusf_kind_t kind;
   } rusf_byte_t;

   typedef struct packed {
      logic set_src;
      logic set_dst;
      logic [31:0] ip;
      logic [15:0] port;
   } rusf_addr_cfg_t;

endpackage

// ===== core/rusf_ram.sv
// Purpose: Simple dual-port memory for cube samples and ramp headers
// Assumes: One write and one read per clock
// Notes: Read data is registered, one cycle after the address
`timescale 1ns/1ps
`default_nettype none
module rusf_ram #(
   parameter int AW = 16,
   parameter int DW = 32
) (
   input wire logic clk_sys_i, // System clock
   input wire logic wr_en_i, // Write strobe
   input wire logic [AW-1:0] wr_addr_i, // Write address
   input wire logic [DW-1:0] wr_data_i, // Write data
   input wire logic [AW-1:0] rd_addr_i, // Read address
   output logic [DW-1:0] rd_data_o // Registered read data
);
   logic [DW-1:0] mem [2**AW];

   // No reset on the array so it maps onto block memory
   always_ff @(posedge clk_sys_i) begin
      if (wr_en_i) begin
         mem[wr_addr_i] <= wr_data_i;
      end
      rd_data_o <= mem[rd_addr_i];
   end
endmodule // rusf_ram
`default_nettype wire

// ===== test/rusf_host_model.sv
// Purpose: Host side of the framer byte stream, collects every datagram
// Assumes: One byte per accepted cycle
// Notes: Stalls every other cycle when slow_i is high
`timescale 1ns/1ps
`default_nettype none
`include "rusf_cfg.svh"
module rusf_host_model import rusf_pkg::*; (
   input wire logic clk_sys_i, // System clock
   input wire logic rst_i, // Async reset, high
   input wire rusf_byte_t tx_i, // Byte from framer
   input wire logic tx_valid_i, // Byte offered
   input wire logic slow_i, // Stall every other cycle
   output logic tx_ready_o // Byte accepted
);
   rusf_byte_t q[$];
   logic [7:0] cur[$];
   int dgrams = 0;
   int len_bad = 0;
   int need;

   // Accept pace; a real host may stall at any byte
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         tx_ready_o <= 1'b0;
      end else begin
         tx_ready_o <= slow_i ? ~tx_ready_o : 1'b1;
      end
   end

   // Collect bytes, check each record's length against its own fields
   always @(posedge clk_sys_i) begin
      if (!rst_i && tx_valid_i && tx_ready_o) begin
         q.push_back(tx_i);
         cur.push_back(tx_i.data);
         if (tx_i.last) begin
            dgrams++;
            if (tx_i.kind == RUSF_K_RECORD) begin
               need = 12 + {cur[6], cur[7]} * ((cur[5] == `RUSF_FMT_F32) ? 4 : 2);
               if (cur.size() != need) len_bad++;
            end
            cur.delete();
         end
      end
   end
endmodule // rusf_host_model
`default_nettype wire

// ===== test/tb_rusf_framer.sv
// Purpose: Self-checking bench of the stream framer
// Assumes: Host model collects all bytes
// Notes: Cubes of two ramps of two samples keep the run short
`timescale 1ns/1ps
`default_nettype none
`include "rusf_cfg.svh"
module tb_rusf_framer import rusf_pkg::*;;
   logic clk_sys_i, rst_i, smp_valid, smp_ready, echo_req, tx_valid, tx_ready, slow;
   rusf_smp_t smp;
   rusf_addr_cfg_t cfg;
   rusf_byte_t tx;
   logic [15:0] spr, rpc, dst_port;
   logic [7:0] stage;
   logic [31:0] echo_tag, src_ip, dst_ip, seq_prev;
   int err_total = 0;
   int num_checks = 0;
   int cubes = 0;
   int cycles = 0;

   rusf_framer dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .smp_i(smp),
      .smp_valid_i(smp_valid), .smp_ready_o(smp_ready), .samples_per_ramp_i(spr),
      .ramps_per_cube_i(rpc), .stage_i(stage), .cfg_i(cfg), .echo_req_i(echo_req),
      .echo_tag_i(echo_tag), .tx_o(tx), .tx_valid_o(tx_valid), .tx_ready_i(tx_ready),
      .src_ip_o(src_ip), .dst_ip_o(dst_ip), .dst_port_o(dst_port));
   rusf_host_model host (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .tx_i(tx),
      .tx_valid_i(tx_valid), .slow_i(slow), .tx_ready_o(tx_ready));

   // ***************************************************
   // Clock, watchdog, reporting
   // ***************************************************
   initial begin
      clk_sys_i = 1'b0;
      forever #20 clk_sys_i = ~clk_sys_i;
   end

   // Cut a hang short; tests need well under a thousand cycles
   always @(posedge clk_sys_i) begin
      cycles++;
      if (cycles == 20000) begin
         err_total++;
         finish_test();
      end
   end

   task automatic finish_test;
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask

   // Big-endian value of n collected bytes
   function automatic logic [31:0] wd(input int a, input int n);
      logic [31:0] v;
      v = 32'h0000_0000;
      for (int i = 0; i < n; i++) v = {v[23:0], host.q[a + i].data};
      return v;
   endfunction

   // Reflected CRC-32 worked out bit by bit, independent of the design
   function automatic logic [31:0] crc_of(input int a, input int n);
      logic [31:0] c;
      c = `RUSF_CRC_INIT;
      for (int i = a; i < a + n; i++) begin
         c = c ^ {24'h00_0000, host.q[i].data};
         for (int b = 0; b < 8; b++) c = c[0] ? ((c >> 1) ^ `RUSF_CRC_POLY) : (c >> 1);
      end
      return ~c;
   endfunction

   // ***************************************************
   // Scenarios
   // ***************************************************
   task automatic put_smp(input logic first, input logic [31:0] v);
      smp_valid <= 1'b1;
      smp <= '{first, 8'h01, 8'h02, v};
      @(posedge clk_sys_i);
      while (smp_ready !== 1'b1) @(posedge clk_sys_i);
   endtask

   // One cube: marker then one record per ramp, fields and CRCs checked
   task automatic run_cube(input logic [7:0] stg, input logic [7:0] fmt, input int sz);
      int b, base, plen, a;
      logic [31:0] v;
      b = host.q.size();
      base = host.dgrams;
      plen = 2 * sz;
      stage <= stg;
      slow <= (sz == 4);
      for (int i = 0; i < 4; i++) put_smp(i % 2 == 0, 32'hA1B2_C3D0 + i);
      smp_valid <= 1'b0;
      @(posedge clk_sys_i);
      check(smp_ready, 1'b0);
      check(host.dgrams, base);
      while (host.dgrams < base + 3) @(posedge clk_sys_i);
      check(host.q[b].kind, RUSF_K_MARKER);
      check(host.q[b].first, 1'b1);
      check(host.q[b + 1].first, 1'b0);
      check(wd(b, 4), `RUSF_MARK_W1);
      check(wd(b + 4, 4), `RUSF_MARK_W2);
      if (cubes > 0) check(wd(b + 8, 4), seq_prev + 1);
      seq_prev = wd(b + 8, 4);
      cubes++;
      check(wd(b + 12, 4), 2 * (12 + plen));
      check(wd(b + 16, 4), 32'h0000_0000);
      check(wd(b + 20, 4), crc_of(b, 20));
      check(host.q[b + 23].last, 1'b1);
      for (int r = 0; r < 2; r++) begin
         a = b + 24 + r * (12 + plen);
         check(host.q[a].kind, RUSF_K_RECORD);
         check(host.q[a].first, 1'b1);
         check(wd(a, 2), 16'h0102);
         check(wd(a + 2, 2), r + 1);
         check(wd(a + 4, 2), {stg, fmt});
         check(wd(a + 6, 2), 2);
         for (int s = 0; s < 2; s++) begin
            v = 32'hA1B2_C3D0 + 2 * r + s;
            if (sz == 2) v = {16'h0000, v[15:0]};
            check(wd(a + 8 + s * sz, sz), v);
         end
         check(wd(a + 8 + plen, 4), crc_of(a, 8 + plen));
         check(host.q[a + 11 + plen].last, 1'b1);
      end
   endtask

   task automatic do_echo;
      int b;
      b = host.q.size();
      echo_tag <= 32'h5A3C_0F81;
      echo_req <= 1'b1;
      @(posedge clk_sys_i);
      echo_req <= 1'b0;
      while (host.q.size() < b + 4) @(posedge clk_sys_i);
      check(wd(b, 4), 32'h5A3C_0F81);
      check(host.q[b + 3].kind, RUSF_K_ECHO);
      check(host.q[b].first, 1'b1);
      check(host.q[b + 3].last, 1'b1);
   endtask

   // Changed addresses hold only until the next reset
   task automatic do_addr;
      cfg <= '{1'b1, 1'b1, 32'hC0A8_0005, 16'h2000};
      @(posedge clk_sys_i);
      cfg <= '0;
      @(posedge clk_sys_i);
      check(src_ip, 32'hC0A8_0005);
      check({dst_ip, dst_port}, {32'hC0A8_0005, 16'h2000});
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      @(posedge clk_sys_i);
      check(src_ip, 32'hC0A8_0001);
      check(dst_ip, 32'hC0A8_0001);
      check(dst_port, 16'h1389);
   endtask

   // ***************************************************
   // Main sequence
   // ***************************************************
   initial begin
      rst_i = 1'b1;
      smp_valid = 1'b0;
      smp = '0;
      cfg = '0;
      echo_req = 1'b0;
      echo_tag = 32'h0000_0000;
      spr = 16'h0002;
      rpc = 16'h0002;
      stage = 8'h00;
      slow = 1'b0;
      seq_prev = 32'h0000_0000;
      repeat (4) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      @(posedge clk_sys_i);
      check(src_ip, 32'hC0A8_0001);
      check(dst_ip, 32'hC0A8_0001);
      check(dst_port, 16'h1389);
      run_cube(`RUSF_STAGE_RAW, `RUSF_FMT_U16, 2);
      do_echo();
      run_cube(`RUSF_STAGE_DC, `RUSF_FMT_S16, 2);
      run_cube(`RUSF_STAGE_FFT, `RUSF_FMT_F32, 4);
      do_addr();
      check(host.len_bad, 0);
      finish_test();
   end
endmodule // tb_rusf_framer
`default_nettype wire
